// ### tli_pkg.sv
// Package of constants and types for the two-level interrupt aggregator.
package tli_pkg;

  // Number of second-level register groups and their order.
  localparam int unsigned NUM_GRP = 10;
  localparam int unsigned GRP_MISC_A = 0;
  localparam int unsigned GRP_TEMP = 1;
  localparam int unsigned GRP_MODE = 2;
  localparam int unsigned GRP_BUCK_ILIM = 3;
  localparam int unsigned GRP_LIN_ILIM = 4;
  localparam int unsigned GRP_BUCK_UV = 5;
  localparam int unsigned GRP_LIN_UV = 6;
  localparam int unsigned GRP_BUCK_OV = 7;
  localparam int unsigned GRP_LIN_OV = 8;
  localparam int unsigned GRP_BUTTON = 9;

  // Register indices: group g has latch at 3g, mask at 3g+1, live at 3g+2.
  localparam logic [7:0] IDX_STRIDE = 8'h03;
  localparam logic [7:0] IDX_LAST_GRP = 8'h1d;
  localparam logic [7:0] IDX_SUMMARY = 8'h1e;

  // Summary bit positions.
  localparam int unsigned SUM_MISC_A = 0;
  localparam int unsigned SUM_MISC_B = 1;
  localparam int unsigned SUM_MODE = 2;
  localparam int unsigned SUM_ILIM = 3;
  localparam int unsigned SUM_UV = 4;
  localparam int unsigned SUM_OV = 5;
  localparam int unsigned SUM_BUTTON = 6;
  localparam int unsigned SUM_EWARN = 7;

  // Implemented latch and mask bits per group, group 9 first.
  localparam logic [NUM_GRP-1:0][7:0] LATCH_VALID = {
    8'hff, 8'h07, 8'h73, 8'h07, 8'h73, 8'h07, 8'h73, 8'h73, 8'hff, 8'hff};
  // Implemented live bits per group, group 9 first.
  localparam logic [NUM_GRP-1:0][7:0] LIVE_VALID = {
    8'h81, 8'h07, 8'h73, 8'h07, 8'h73, 8'h07, 8'h73, 8'h00, 8'hff, 8'h07};

  // Reset values.
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [NUM_GRP-1:0][7:0] MASK_RST = LATCH_VALID;

  // Register access request from the device's serial register engine.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tli_req_t;

  // Kind of register selected by an index.
  typedef enum logic [1:0] {
    TLI_SEL_LATCH,
    TLI_SEL_MASK,
    TLI_SEL_LIVE,
    TLI_SEL_NONE
  } tli_sel_t;

  // Complete state of the aggregator.
  typedef struct packed {
    logic [NUM_GRP-1:0][7:0] latch;
    logic [NUM_GRP-1:0][7:0] mask;
    logic                    ewarn;
    logic [7:0]              summary;
    logic [7:0]              rdata;
    logic                    irq_oe;
  } tli_state_t;

endpackage

// ### tli_irq_aggregator.sv
// Two-level interrupt aggregator with event latches, masks, live bits and summary.
//
// Contract
// - A latch sets on its event, is always readable, clears on write-one.
// - A masked latch has no effect on the interrupt output.
// - An unmasked set latch holds the interrupt output low.
// - Live bits read the present level of the triggering signal.
// - Interrupt output is the OR of all unmasked latches and the early-warning bit.
// - A summary register names the group; group registers name the source.
// - A group summary bit is set only while an unmasked latch of its group is set.
// - Clearing the last unmasked latch behind a summary bit clears that bit automatically.
// - Output stays asserted while any summary bit is set.
// - Current-limit summary covers buck and linear current-limit groups.
// - Undervoltage summary covers buck and linear undervoltage groups.
// - Overvoltage summary covers buck and linear overvoltage groups.
// - Misc A, misc B, mode and button summary bits follow only their group.
// - Early-warning summary bit sets on an early-warning event.
// - Events with bypassed fault protection still latch and interrupt.
`timescale 1ns/1ps
`default_nettype none

module tli_irq_aggregator
  import tli_pkg::*;
(
  // Clock and reset.
  input  wire logic                              CLK,
  input  wire logic                              RESET_N,
  // Register access from the serial register engine.
  input  wire tli_pkg::tli_req_t                 REQ,
  output var  logic [7:0]                        RDATA,
  // Event pulses and live levels from the monitors.
  input  wire logic [tli_pkg::NUM_GRP-1:0][7:0]  EVENT,
  input  wire logic [tli_pkg::NUM_GRP-1:0][7:0]  LIVE,
  input  wire logic                              EWARN_EVENT,
  // Open-drain interrupt pin, active low.
  output var  logic                              IRQ_OUT_N,
  output var  logic                              IRQ_OE
);
  import tli_pkg::*;

  tli_state_t s_q;
  tli_state_t s_d;

  // Decodes the register kind of an index; indices past the last group select none.
  function automatic tli_sel_t sel_of(input logic [7:0] addr);
    tli_sel_t sel;
    sel = TLI_SEL_NONE;
    if (addr <= IDX_LAST_GRP)
    begin
      unique case (addr % IDX_STRIDE)
        8'h00:   sel = TLI_SEL_LATCH;
        8'h01:   sel = TLI_SEL_MASK;
        8'h02:   sel = TLI_SEL_LIVE;
        default: sel = TLI_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Group number of an index; only meaningful when the index selects a group register.
  function automatic logic [3:0] grp_of(input logic [7:0] addr);
    logic [7:0] g;
    g = addr / IDX_STRIDE;
    return g[3:0];
  endfunction

  // Decoded request and the unmasked pending bits of the next state.
  logic [NUM_GRP-1:0][7:0] pend_d;
  logic [NUM_GRP-1:0]      grp_pend;
  tli_sel_t                sel;
  logic [3:0]              grp;

  // Next state: latches, masks, summary and read data.
  always_comb
  begin
    s_d = s_q;
    sel = sel_of(REQ.addr);
    grp = grp_of(REQ.addr);
    // Set beats clear so an event coinciding with the clearing write survives.
    for (int g = 0; g < NUM_GRP; g++)
    begin
      if (REQ.wr && sel == TLI_SEL_LATCH && grp == 4'(g))
      begin
        s_d.latch[g] = s_q.latch[g] & ~REQ.wdata;
      end
      if (REQ.wr && sel == TLI_SEL_MASK && grp == 4'(g))
      begin
        s_d.mask[g] = REQ.wdata & LATCH_VALID[g];
      end
      // Bypassed faults still arrive as events, so nothing gates them here.
      s_d.latch[g] = (s_d.latch[g] | EVENT[g]) & LATCH_VALID[g];
    end
    if (REQ.wr && REQ.addr == IDX_SUMMARY && REQ.wdata[SUM_EWARN])
    begin
      s_d.ewarn = 1'b0;
    end
    s_d.ewarn = s_d.ewarn | EWARN_EVENT;

    // Summary follows the next latch state so pin and summary move together.
    for (int g = 0; g < NUM_GRP; g++)
    begin
      pend_d[g] = s_d.latch[g] & ~s_d.mask[g];
      grp_pend[g] = |pend_d[g];
    end
    s_d.summary[SUM_MISC_A] = grp_pend[GRP_MISC_A];
    s_d.summary[SUM_MISC_B] = grp_pend[GRP_TEMP];
    s_d.summary[SUM_MODE] = grp_pend[GRP_MODE];
    s_d.summary[SUM_ILIM] = grp_pend[GRP_BUCK_ILIM] | grp_pend[GRP_LIN_ILIM];
    s_d.summary[SUM_UV] = grp_pend[GRP_BUCK_UV] | grp_pend[GRP_LIN_UV];
    s_d.summary[SUM_OV] = grp_pend[GRP_BUCK_OV] | grp_pend[GRP_LIN_OV];
    s_d.summary[SUM_BUTTON] = grp_pend[GRP_BUTTON];
    s_d.summary[SUM_EWARN] = s_d.ewarn;
    // Group summary bits clear themselves once their latches are gone; no write is needed.
    s_d.irq_oe = |s_d.summary;

    // Read data is registered; unmapped indices read zero.
    s_d.rdata = 8'h00;
    if (REQ.rd)
    begin
      if (REQ.addr == IDX_SUMMARY)
      begin
        s_d.rdata = s_q.summary;
      end
      else
      begin
        for (int g = 0; g < NUM_GRP; g++)
        begin
          if (grp == 4'(g))
          begin
            unique case (sel)
              TLI_SEL_LATCH: s_d.rdata = s_q.latch[g];
              TLI_SEL_MASK:  s_d.rdata = s_q.mask[g];
              TLI_SEL_LIVE:  s_d.rdata = LIVE[g] & LIVE_VALID[g];
              TLI_SEL_NONE:  s_d.rdata = 8'h00;
            endcase
          end
        end
      end
    end
  end

  // State register.
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_q.latch <= {NUM_GRP{LATCH_RST}};
      s_q.mask <= MASK_RST;
      s_q.ewarn <= 1'b0;
      s_q.summary <= 8'h00;
      s_q.rdata <= 8'h00;
      s_q.irq_oe <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // The pin is only ever pulled low; the board pull-up gives the high level.
  assign IRQ_OUT_N = 1'b0;
  assign IRQ_OE = s_q.irq_oe;
  assign RDATA = s_q.rdata;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  // Unmasked pending bits seen from the registered state.
  logic [NUM_GRP-1:0][7:0] pend_q;
  always_comb
  begin
    for (int g = 0; g < NUM_GRP; g++)
    begin
      pend_q[g] = s_q.latch[g] & ~s_q.mask[g];
    end
  end

  // Latch bits that a write-one request is clearing in this cycle.
  logic [NUM_GRP-1:0][7:0] clr_bits;
  always_comb
  begin
    for (int g = 0; g < NUM_GRP; g++)
    begin
      clr_bits[g] = 8'h00;
      if (REQ.wr && sel == TLI_SEL_LATCH && grp == 4'(g))
      begin
        clr_bits[g] = REQ.wdata;
      end
    end
  end

  AST_LATCH_SETS: assert property (
    |(EVENT & LATCH_VALID) |=> ((s_q.latch & $past(EVENT & LATCH_VALID))
                               == $past(EVENT & LATCH_VALID)))
    else $error("Event did not set its latch.");

  AST_MASK_BLOCKS: assert property (
    (pend_q == '0) && !s_q.ewarn |-> !IRQ_OE)
    else $error("Masked latches drove the interrupt pin.");

  AST_UNMASKED_DRIVES: assert property (
    (pend_q != '0) |-> IRQ_OE)
    else $error("Unmasked set latch did not drive the interrupt pin.");

  AST_OR_OF_SUMMARY: assert property (
    IRQ_OE == (|s_q.summary))
    else $error("Interrupt pin disagrees with summary.");

  AST_ILIM_SUMMARY: assert property (
    s_q.summary[SUM_ILIM] == ((|pend_q[GRP_BUCK_ILIM]) | (|pend_q[GRP_LIN_ILIM])))
    else $error("Current-limit summary wrong.");

  AST_UV_OV_SUMMARY: assert property (
    s_q.summary[SUM_UV] == ((|pend_q[GRP_BUCK_UV]) | (|pend_q[GRP_LIN_UV]))
    && s_q.summary[SUM_OV] == ((|pend_q[GRP_BUCK_OV]) | (|pend_q[GRP_LIN_OV])))
    else $error("Voltage summary wrong.");

  AST_ZERO_WRITE_KEEPS: assert property (
    REQ.wr && sel == TLI_SEL_LATCH && REQ.wdata == 8'h00
    |=> s_q.latch == $past(s_q.latch | (EVENT & LATCH_VALID)))
    else $error("Writing zero changed a latch.");

  AST_EWARN_SETS: assert property (
    EWARN_EVENT |=> s_q.summary[SUM_EWARN] && IRQ_OE)
    else $error("Early warning did not reach summary.");

  AST_RESERVED_ZERO: assert property (
    (s_q.latch & ~LATCH_VALID) == '0 && (s_q.mask & ~LATCH_VALID) == '0)
    else $error("Reserved bit became set.");

  AST_LIVE_READ: assert property (
    REQ.rd && sel == TLI_SEL_LIVE && grp == 4'(GRP_TEMP)
    |=> RDATA == $past(LIVE[GRP_TEMP]))
    else $error("Live read returned a stored value.");

  // Further checks on the latch, mask, pin, summary and read paths; each names the path it guards.
  // A write of ones clears exactly the addressed bits unless an event lands on them.
  AST_CLEAR_ON_ONE: assert property (
    (|clr_bits) |=> ((s_q.latch & $past(clr_bits & ~EVENT)) == '0))
    else $error("Write of ones did not clear the latch.");

  // The hazard here is a clear racing an event; the event must survive.
  AST_SET_WINS: assert property (
    (|(clr_bits & EVENT & LATCH_VALID))
    |=> ((s_q.latch & $past(clr_bits & EVENT & LATCH_VALID))
         == $past(clr_bits & EVENT & LATCH_VALID)))
    else $error("Clearing write swallowed a coinciding event.");

  // Without an event or a clearing write a latch keeps its value.
  AST_LATCH_HOLDS: assert property (
    (clr_bits == '0) && ((EVENT & LATCH_VALID) == '0) |=> $stable(s_q.latch))
    else $error("Latch changed with no event and no write.");

  // Bypassed faults arrive as ordinary events, and masking must not stop them latching.
  AST_MASKED_STILL_LATCHES: assert property (
    (|(EVENT & LATCH_VALID & s_q.mask))
    |=> ((s_q.latch & $past(EVENT & LATCH_VALID & s_q.mask))
         == $past(EVENT & LATCH_VALID & s_q.mask)))
    else $error("Masked event was not latched.");

  // Masks change only through their own write.
  AST_MASK_HOLDS: assert property (
    !(REQ.wr && sel == TLI_SEL_MASK) |=> $stable(s_q.mask))
    else $error("Mask changed without a mask write.");

  // A mask write lands at its edge with reserved positions forced to zero.
  AST_MASK_WRITE: assert property (
    REQ.wr && sel == TLI_SEL_MASK && grp == 4'(GRP_BUCK_ILIM)
    |=> s_q.mask[GRP_BUCK_ILIM] == $past(REQ.wdata & LATCH_VALID[GRP_BUCK_ILIM]))
    else $error("Mask write did not land.");

  // The pin enable is exactly the OR of every unmasked latch and the warning.
  AST_OUT_IS_OR: assert property (
    IRQ_OE == ((pend_q != '0) || s_q.ewarn))
    else $error("Interrupt pin is not the OR of unmasked latches.");

  // An unmasked event shows on the pin one cycle later, not two.
  AST_EVENT_RAISES_PIN: assert property (
    (|(EVENT & LATCH_VALID & ~s_q.mask)) && !(REQ.wr && sel == TLI_SEL_MASK)
    |=> IRQ_OE)
    else $error("Unmasked event did not reach the pin in one cycle.");

  // The pin lets go only once nothing unmasked is left.
  AST_RELEASE: assert property (
    $fell(IRQ_OE) |-> (pend_q == '0) && !s_q.ewarn)
    else $error("Interrupt pin released with a request pending.");

  // Only a host write can be what released the pin.
  AST_RELEASE_CAUSE: assert property (
    $fell(IRQ_OE) |-> $past((|clr_bits) || (REQ.wr && sel == TLI_SEL_MASK)
                            || (REQ.wr && REQ.addr == IDX_SUMMARY)))
    else $error("Interrupt pin released with no host write.");

  // Clearing the last pending latch lets the pin go on the very next edge.
  AST_CLEAR_DROPS_PIN: assert property (
    IRQ_OE && !s_q.ewarn && !EWARN_EVENT && ((pend_q & ~clr_bits) == '0)
    && ((EVENT & LATCH_VALID) == '0) && !(REQ.wr && sel == TLI_SEL_MASK)
    |=> !IRQ_OE)
    else $error("Pin stayed asserted after the last latch was cleared.");

  // A group summary bit never stands without an unmasked latch behind it.
  AST_SUMMARY_NEEDS_PEND: assert property (
    (s_q.summary[6:0] != 7'h00) |-> (pend_q != '0) && IRQ_OE)
    else $error("Summary bit set with no unmasked latch.");

  // Summary bits drop by themselves once the latches behind them are gone.
  AST_SUMMARY_AUTO_CLEAR: assert property (
    (pend_q == '0) |-> (s_q.summary[6:0] == 7'h00))
    else $error("Summary bit outlived its latches.");

  // Single-group summary bits follow their own group and nothing else.
  AST_SINGLE_GROUP_SUMMARY: assert property (
    s_q.summary[SUM_MISC_A] == (|pend_q[GRP_MISC_A])
    && s_q.summary[SUM_MISC_B] == (|pend_q[GRP_TEMP])
    && s_q.summary[SUM_MODE] == (|pend_q[GRP_MODE])
    && s_q.summary[SUM_BUTTON] == (|pend_q[GRP_BUTTON]))
    else $error("Single-group summary bit wrong.");

  // A linear current-limit event alone is enough to raise the shared bit.
  AST_LIN_ILIM_EVENT: assert property (
    (|(EVENT[GRP_LIN_ILIM] & LATCH_VALID[GRP_LIN_ILIM] & ~s_q.mask[GRP_LIN_ILIM]))
    && !(REQ.wr && sel == TLI_SEL_MASK) |=> s_q.summary[SUM_ILIM])
    else $error("Linear current-limit event missed the summary.");

  // A linear undervoltage event alone is enough to raise the shared bit.
  AST_LIN_UV_EVENT: assert property (
    (|(EVENT[GRP_LIN_UV] & LATCH_VALID[GRP_LIN_UV] & ~s_q.mask[GRP_LIN_UV]))
    && !(REQ.wr && sel == TLI_SEL_MASK) |=> s_q.summary[SUM_UV])
    else $error("Linear undervoltage event missed the summary.");

  // The early warning is sticky until the host writes its bit.
  AST_EWARN_HOLDS: assert property (
    s_q.ewarn && !(REQ.wr && REQ.addr == IDX_SUMMARY && REQ.wdata[SUM_EWARN])
    |=> s_q.summary[SUM_EWARN])
    else $error("Early warning dropped without a clear.");

  // A clearing write with no new warning empties the bit.
  AST_EWARN_CLEARS: assert property (
    REQ.wr && REQ.addr == IDX_SUMMARY && REQ.wdata[SUM_EWARN] && !EWARN_EVENT
    |=> !s_q.summary[SUM_EWARN])
    else $error("Early warning did not clear on write.");

  // Nothing but the warning input may raise the warning bit.
  AST_EWARN_NO_SPURIOUS: assert property (
    !s_q.ewarn && !EWARN_EVENT |=> !s_q.summary[SUM_EWARN])
    else $error("Early warning rose with no event.");

  // The summary register reads the first level as it stood at the request.
  AST_SUMMARY_READ: assert property (
    REQ.rd && REQ.addr == IDX_SUMMARY |=> RDATA == $past(s_q.summary))
    else $error("Summary read returned the wrong value.");

  // Latches read back the stored value before any same-cycle write.
  AST_LATCH_READ: assert property (
    REQ.rd && sel == TLI_SEL_LATCH |=> RDATA == $past(s_q.latch[grp]))
    else $error("Latch read returned the wrong value.");

  // Mask reads show only implemented bits.
  AST_MASK_READ: assert property (
    REQ.rd && sel == TLI_SEL_MASK |=> RDATA == $past(s_q.mask[grp] & LATCH_VALID[grp]))
    else $error("Mask read returned the wrong value.");

  // Every live register reads the present level, reserved positions as zero.
  AST_LIVE_ALL: assert property (
    REQ.rd && sel == TLI_SEL_LIVE |=> RDATA == $past(LIVE[grp] & LIVE_VALID[grp]))
    else $error("Live read returned the wrong value.");

  // Indices past the summary answer zero.
  AST_UNMAPPED_READ: assert property (
    REQ.rd && REQ.addr > IDX_SUMMARY |=> RDATA == 8'h00)
    else $error("Unmapped read returned data.");

  // Read data stands for one cycle only, so a stale value cannot be mistaken.
  AST_IDLE_READ_ZERO: assert property (
    !REQ.rd |=> RDATA == 8'h00)
    else $error("Read data stood without a read.");

endmodule

`default_nettype wire

// ### tli_host_model.sv
// Host processor model that makes register accesses and services interrupts.
`timescale 1ns/1ps
`default_nettype none
module tli_host_model
  import tli_pkg::*;
(
  // Clock.
  input  wire logic              CLK,
  // Register access and read data.
  output var  tli_pkg::tli_req_t REQ,
  input  wire logic [7:0]        RDATA
);
  initial REQ = '0;
  // Strobes rise after a falling edge and drop at the next one; idle lines
  // show the inverse of the last value so a stale address never matches.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge CLK);
    REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge CLK);
    REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask
  // Read data stands for one cycle after the taking edge, so sample it then.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge CLK);
    REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge CLK);
    REQ = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    v = RDATA;
  endtask
  // Service order: summary first, then the group latch, then write ones.
  task automatic service(input int g, output logic [7:0] s, output logic [7:0] l);
    rd(IDX_SUMMARY, s);
    rd(8'(3 * g), l);
    wr(8'(3 * g), l);
  endtask
endmodule
`default_nettype wire

// ### tli_irq_aggregator_tb_top.sv
// Self-checking testbench for the two-level interrupt aggregator.
`timescale 1ns/1ps
`default_nettype none
module tli_irq_aggregator_tb_top;
  import tli_pkg::*;
  logic                    clk = 1'b0;
  logic                    reset_n = 1'b0;
  tli_req_t                req;
  logic [7:0]              rdata;
  logic [NUM_GRP-1:0][7:0] ev = '0;
  logic [NUM_GRP-1:0][7:0] live = '0;
  logic                    ewarn = 1'b0;
  logic                    irq_n;
  logic                    irq_oe;
  logic [7:0]              d;
  logic [7:0]              s;
  int                      fails = 0;
  int                      num_checks = 0;
  // The open-drain pin has a pull-up, so it is high unless the block drives it.
  wire                     pin = irq_oe ? irq_n : 1'b1;
  localparam int SUM_OF [NUM_GRP] = '{0, 1, 2, 3, 3, 4, 4, 5, 5, 6};

  always #5 clk = ~clk;

  tli_irq_aggregator tli_irq_aggregator_i (.CLK(clk), .RESET_N(reset_n), .REQ(req),
    .RDATA(rdata), .EVENT(ev), .LIVE(live), .EWARN_EVENT(ewarn), .IRQ_OUT_N(irq_n),
    .IRQ_OE(irq_oe));
  tli_host_model tli_host_model_i (.CLK(clk), .REQ(req), .RDATA(rdata));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  // One-cycle event pulse; the latch is visible at the falling edge after it.
  task automatic pulse(input int g, input logic [7:0] b);
    @(negedge clk);
    ev[g] = b;
    @(negedge clk);
    ev[g] = '0;
  endtask
  task automatic t_reset();
    for (int g = 0; g < NUM_GRP; g++)
    begin
      tli_host_model_i.rd(8'(3 * g), d);
      chk("latch", d, LATCH_RST);
      tli_host_model_i.rd(8'(3 * g + 1), d);
      chk("mask", d, MASK_RST[g]);
    end
    tli_host_model_i.rd(8'h1f, d);
    chk("unmapped", d, 8'h00);
    chk("pin idle", {7'h0, pin}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_mask();
    pulse(GRP_BUCK_ILIM, 8'h01);
    chk("masked pin", {7'h0, pin}, 8'h01);
    tli_host_model_i.rd(8'h09, d);
    chk("masked latch", d, 8'h01);
    tli_host_model_i.rd(IDX_SUMMARY, d);
    chk("masked sum", d, 8'h00);
    tli_host_model_i.wr(8'h0a, 8'h00);
    chk("unmasked pin", {7'h0, pin}, 8'h00);
    tli_host_model_i.wr(8'h09, 8'h00);
    tli_host_model_i.rd(8'h09, d);
    chk("zero write", d, 8'h01);
    ev[GRP_BUCK_ILIM] = 8'h01;
    tli_host_model_i.wr(8'h09, 8'h01);
    ev[GRP_BUCK_ILIM] = 8'h00;
    tli_host_model_i.service(GRP_BUCK_ILIM, s, d);
    chk("set wins", d, 8'h01);
    chk("ilim sum", s, 8'h08);
    tli_host_model_i.rd(IDX_SUMMARY, d);
    chk("auto clear", d, 8'h00);
    chk("released", {7'h0, pin}, 8'h01);
    tli_host_model_i.wr(8'h0a, LATCH_VALID[GRP_BUCK_ILIM]);
    $display("test mask done");
  endtask
  // Every group in turn reports through its own summary bit only.
  task automatic t_groups();
    for (int g = 0; g < NUM_GRP; g++)
    begin
      tli_host_model_i.wr(8'(3 * g + 1), 8'h00);
      pulse(g, 8'h01);
      chk("group pin", {7'h0, pin}, 8'h00);
      tli_host_model_i.service(g, s, d);
      chk("group sum", s, 8'(1 << SUM_OF[g]));
      chk("after clear", {7'h0, pin}, 8'h01);
      tli_host_model_i.wr(8'(3 * g + 1), LATCH_VALID[g]);
    end
    $display("test groups done");
  endtask
  task automatic t_live();
    live = {NUM_GRP{8'ha5}};
    for (int g = 0; g < NUM_GRP; g++)
    begin
      tli_host_model_i.rd(8'(3 * g + 2), d);
      chk("live", d, 8'ha5 & LIVE_VALID[g]);
    end
    tli_host_model_i.wr(8'h0d, 8'hf8);
    tli_host_model_i.rd(8'h0d, d);
    chk("reserved mask", d, 8'h00);
    $display("test live done");
  endtask
  task automatic t_ewarn();
    @(negedge clk);
    ewarn = 1'b1;
    @(negedge clk);
    ewarn = 1'b0;
    chk("warn pin", {7'h0, pin}, 8'h00);
    tli_host_model_i.rd(IDX_SUMMARY, d);
    chk("warn sum", d, 8'h80);
    tli_host_model_i.wr(IDX_SUMMARY, 8'h80);
    chk("warn clear", {7'h0, pin}, 8'h01);
    $display("test ewarn done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang anywhere counts as a mismatch.
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_mask();
    t_groups();
    t_live();
    t_ewarn();
    end_sim();
  end
endmodule
`default_nettype wire
